// ===== cdio_map.sv
/*
 * Crane drive I/O signal map: routes synchronised input terminals to the
 * dedicated logistics functions, derives the operating mode, detects system
 * failures, and drives output terminals and sequence relays with selectable
 * polarity. Registers sit behind an APB slave.
 * Assumes pclk at 40 MHz; terminal and switch inputs are asynchronous pins,
 * flux, limit-hit and position inputs come from logic on pclk.
 */
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// - Each input terminal selector takes a code 107..113 and routes that terminal's level to the chosen function.
// - Codes 107 and 112 enable or disable limit dog detection 1 and 2 by the level of their input.
// - Code 108 picks full-closed control when inactive and fork control when active.
// - Code 109 switches between position feed and speed feed.
// - Code 110 picks the acceleration and deceleration pattern while full-closed control is active.
// - Code 111 turning on is a crane emergency stop and counts as a system failure.
// - Code 113 picks extended or standard mode and is honoured in every mode.
// - Inputs are honoured only in their valid modes as the mode table gives.
// - In speed feed, limit dog failure detection applies only when its enable setting is on.
// - Each output selector takes a function code for positive logic or the code plus 100 for negative logic.
// - Each function assigned to a digital-output or relay-output selector is written to its sequence relay.
// - Brake-open request turns on when flux reaches its value after pre-excitation or start turns on; the code holds it off outside full-closed control.
// - System failure output is on whenever any system failure has been detected; the code holds it off in standard mode.
// - Position window output is on while the position is within target plus or minus the detection width; the code holds it off outside position feed.
module cdio_map
  import cdio_pkg::*;
(
  input  wire  logic                       pclk,                   // Control clock, 40 MHz
  input  wire  logic                       presetn,                // Asynchronous reset, active low
  input  wire  logic                       psel,                   // APB select
  input  wire  logic                       penable,                // APB access phase
  input  wire  logic                       pwrite,                 // APB direction
  input  wire  logic [11:0]                paddr,                  // APB byte address
  input  wire  logic [31:0]                pwdata,                 // APB write data
  output logic       [31:0]                prdata,                 // APB read data
  output logic                             pready,                 // APB ready
  output logic                             pslverr,                // APB error on unmapped address
  input  wire  logic [cdio_pkg::NUM_IN-1:0] in_term,               // Configurable input terminals
  input  wire  logic                       pre_excitation_input,   // Pre-excitation pin
  input  wire  logic                       start_input,            // Start pin
  input  wire  logic                       flux_reached,           // Estimated flux at specified value
  input  wire  logic                       limit_hit1,             // Limit dog 1 position hit
  input  wire  logic                       limit_hit2,             // Limit dog 2 position hit
  input  wire  logic signed [31:0]         current_position,       // Current crane position
  output logic [cdio_pkg::NUM_OUT-1:0]     out_term,               // Output terminals
  output logic [cdio_pkg::NUM_REL-1:0]     seq_relay,              // Sequence-program relays
  output logic                             accel_pattern_sel,      // Alternate accel pattern in use
  output logic [1:0]                       op_mode,                // Current operating mode
  output logic                             irq                     // Level interrupt
);
  import cdio_pkg::*;

  typedef struct packed {
    logic [NUM_IN-1:0][7:0]   in_sel;
    logic [NUM_OSEL-1:0][8:0] out_sel;
    logic                     lim_fault_en;
    logic [31:0]              pos_width;
    logic [31:0]              target;
    logic [NUM_EV-1:0]        irq_stat;
    logic [NUM_EV-1:0]        irq_en;
    logic [NUM_IN-1:0]        in_m;        // First synchroniser stage
    logic [NUM_IN-1:0]        in_s;        // Second synchroniser stage
    logic [1:0]               pin_m;
    logic [1:0]               pin_s;
    logic                     exc_seen;    // Pre-excitation or start seen
    logic                     brake;
    logic                     fail;
    logic                     window;
    logic                     estop_prev;
    logic [NUM_OUT-1:0]       outs;
    logic [NUM_REL-1:0]       relays;
    logic                     accel;
    logic                     ack;
    logic [31:0]              rdata;
    logic                     err;
  } cdio_state_t;

  cdio_state_t s_q;
  cdio_state_t s_d;

  // Level of the function with this code; an unassigned code stays off
  function automatic logic fn_level(input logic [NUM_IN-1:0][7:0] sel,
                                    input logic [NUM_IN-1:0] lvl,
                                    input logic [7:0] code);
    logic r;
    r = 1'b0;
    for (int i = 0; i < NUM_IN; i++) begin
      if (sel[i] == code) begin
        r = r | lvl[i];
      end
    end
    return r;
  endfunction : fn_level

  // Drive level of one output selector; unknown codes drive low
  function automatic logic out_level(input logic [8:0] code, input logic brk,
                                     input logic fl, input logic win);
    logic r;
    r = 1'b0;
    if (code == FN_BRAKE_OPEN) r = brk;
    else if (code == FN_SYS_FAIL) r = fl;
    else if (code == FN_POS_WINDOW) r = win;
    else if (code == FN_BRAKE_OPEN + NEG_OFS) r = !brk;
    else if (code == FN_SYS_FAIL + NEG_OFS) r = !fl;
    else if (code == FN_POS_WINDOW + NEG_OFS) r = !win;
    return r;
  endfunction : out_level

  logic             f_dog1;
  logic             f_fork;
  logic             f_feed;
  logic             f_accel;
  logic             f_estop;
  logic             f_dog2;
  logic             f_ext;
  cdio_mode_t       mode;
  logic             full_closed;
  logic             estop_ok;
  logic             lim_fault;
  logic             fail_now;
  logic             brake_now;
  logic             win_now;
  logic signed [32:0] pos_diff;
  logic [32:0]      pos_abs;
  logic             wr;
  logic             rd_access;
  logic [11:0]      woff;
  logic [NUM_EV-1:0] ev;

  // Dedicated input functions, read only from the second sync stage
  always_comb begin
    f_dog1  = fn_level(s_q.in_sel, s_q.in_s, FN_LIMIT_DOG);
    f_fork  = fn_level(s_q.in_sel, s_q.in_s, FN_FORK_SEL);
    f_feed  = fn_level(s_q.in_sel, s_q.in_s, FN_FEED_SW);
    f_accel = fn_level(s_q.in_sel, s_q.in_s, FN_ACCEL_PAT);
    f_estop = fn_level(s_q.in_sel, s_q.in_s, FN_ESTOP);
    f_dog2  = fn_level(s_q.in_sel, s_q.in_s, FN_LIMIT_DOG2);
    f_ext   = fn_level(s_q.in_sel, s_q.in_s, FN_EXT_MODE);
  end

  // Mode decode; the extended-mode input is honoured everywhere, so it gates the rest
  always_comb begin
    if (!f_ext) begin
      mode = CDIO_STANDARD;
    end else if (f_fork) begin
      mode = CDIO_FORK;
    end else if (f_feed) begin
      mode = CDIO_SPEED_FEED;
    end else begin
      mode = CDIO_POS_FEED;
    end
    full_closed = (mode == CDIO_POS_FEED) || (mode == CDIO_SPEED_FEED);
  end

  // Failure sources and validity by mode
  always_comb begin
    estop_ok  = (mode != CDIO_STANDARD) && f_estop;
    lim_fault = full_closed && (mode == CDIO_POS_FEED || s_q.lim_fault_en)
                && ((f_dog1 && limit_hit1) || (f_dog2 && limit_hit2));
    // Emergency stop counts on its turn-on edge so a held switch cannot mask a clear
    fail_now  = (estop_ok && !s_q.estop_prev) || lim_fault;
  end

  // Position window: 33-bit difference so no wrap at the range ends
  always_comb begin
    pos_diff = 33'(current_position) - 33'(signed'(s_q.target));
    pos_abs  = pos_diff[32] ? 33'(-pos_diff) : 33'(pos_diff);
    win_now  = (mode == CDIO_POS_FEED) && (pos_abs <= {1'b0, s_q.pos_width});
    brake_now = full_closed && s_q.exc_seen && flux_reached;
  end

  // APB decode; writes land at the edge where pready is seen high
  always_comb begin
    rd_access = psel && penable && !s_q.ack;
    wr        = psel && penable && s_q.ack && pwrite;
    woff      = paddr - ADR_OUT_SEL;
  end

  // Next-state logic
  always_comb begin
    s_d = s_q;
    // Two-flop synchronisers for pins
    s_d.in_m  = in_term;
    s_d.in_s  = s_q.in_m;
    s_d.pin_m = {start_input, pre_excitation_input};
    s_d.pin_s = s_q.pin_m;

    // Excitation command seen; dropping both commands ends the request
    s_d.exc_seen   = |s_q.pin_s;
    s_d.brake      = brake_now;
    s_d.window     = win_now;
    s_d.estop_prev = estop_ok;
    s_d.accel      = full_closed && f_accel;

    // Latched failure: a new detection wins over a software clear
    if (wr && paddr == ADR_CTRL && pwdata[CTRL_FAIL_CLR]) begin
      s_d.fail = 1'b0;
    end
    if (fail_now) begin
      s_d.fail = 1'b1;
    end

    // Output terminals and relays; system failure is invalid in standard mode
    for (int i = 0; i < NUM_OUT; i++) begin
      s_d.outs[i] = out_level(s_q.out_sel[i], s_q.brake,
                              s_q.fail && mode != CDIO_STANDARD, s_q.window);
    end
    for (int i = 0; i < NUM_REL; i++) begin
      s_d.relays[i] = out_level(s_q.out_sel[NUM_OUT+i], s_q.brake,
                                s_q.fail && mode != CDIO_STANDARD, s_q.window);
    end

    // Interrupt events: rising edges of the three functions
    ev = '0;
    ev[EV_FAIL]   = fail_now && !s_q.fail;
    ev[EV_BRAKE]  = brake_now && !s_q.brake;
    ev[EV_WINDOW] = win_now && !s_q.window;

    // APB handshake and read data capture
    s_d.ack = rd_access;
    if (rd_access) begin
      s_d.err   = 1'b0;
      s_d.rdata = WORD_RST;
      if (paddr[1:0] != 2'b00) begin
        s_d.err = 1'b1;
      end else if (paddr < ADR_IN_SEL + 12'(4 * NUM_IN)) begin
        s_d.rdata = {24'h000000, s_q.in_sel[paddr[5:2]]};
      end else if (paddr >= ADR_OUT_SEL && paddr < ADR_OUT_SEL + 12'(4 * NUM_OSEL)) begin
        s_d.rdata = {23'h0, s_q.out_sel[woff[6:2]]};
      end else begin
        unique case (paddr)
          ADR_CTRL:     s_d.rdata = {31'h0, s_q.lim_fault_en};
          ADR_WIDTH:    s_d.rdata = s_q.pos_width;
          ADR_TARGET:   s_d.rdata = s_q.target;
          ADR_STATUS:   s_d.rdata = {6'h00, s_q.relays, 1'b0, s_q.outs, 2'b00,
                                     s_q.accel, s_q.window, s_q.brake, s_q.fail, op_mode};
          ADR_IRQ_STAT: s_d.rdata = {29'h0, s_q.irq_stat};
          ADR_IRQ_CLR:  s_d.rdata = WORD_RST;
          ADR_IRQ_EN:   s_d.rdata = {29'h0, s_q.irq_en};
          default:      s_d.err   = 1'b1;
        endcase
      end
    end

    // Register writes
    if (wr && !s_q.err) begin
      if (paddr < ADR_IN_SEL + 12'(4 * NUM_IN)) begin
        s_d.in_sel[paddr[5:2]] = pwdata[7:0];
      end else if (paddr >= ADR_OUT_SEL && paddr < ADR_OUT_SEL + 12'(4 * NUM_OSEL)) begin
        s_d.out_sel[woff[6:2]] = pwdata[8:0];
      end else begin
        unique case (paddr)
          ADR_CTRL:   s_d.lim_fault_en = pwdata[CTRL_LIM_FAULT_EN];
          ADR_WIDTH:  s_d.pos_width    = pwdata;
          ADR_TARGET: s_d.target       = pwdata;
          ADR_IRQ_CLR: s_d.irq_stat    = s_q.irq_stat & ~pwdata[NUM_EV-1:0];
          ADR_IRQ_EN: s_d.irq_en       = pwdata[NUM_EV-1:0];
          default: ;
        endcase
      end
    end
    // Events are set after the clear so a coincident event is kept
    s_d.irq_stat = s_d.irq_stat | ev;
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
      for (int i = 0; i < NUM_IN; i++) begin
        s_q.in_sel[i] <= IN_SEL_RST;
      end
      for (int i = 0; i < NUM_OSEL; i++) begin
        s_q.out_sel[i] <= OUT_SEL_RST;
      end
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs
  assign prdata            = s_q.rdata;
  assign pready            = s_q.ack;
  assign pslverr           = s_q.ack && s_q.err;
  assign out_term          = s_q.outs;
  assign seq_relay         = s_q.relays;
  assign accel_pattern_sel = s_q.accel;
  assign op_mode           = mode;
  assign irq               = |(s_q.irq_stat & s_q.irq_en);
endmodule : cdio_map

`default_nettype wire

// ===== cdio_pkg.sv
/*
 * Package for the crane drive I/O signal map: function codes, register map,
 * field positions and reset values.
 * Assumes a 32-bit APB register bus and one control clock.
 */
package cdio_pkg;
  // Terminal counts
  localparam int NUM_IN   = 12;  // Input function selectors
  localparam int NUM_OUT  = 7;   // Physical output terminals
  localparam int NUM_REL  = 10;  // Seven digital-output plus three relay-output selectors
  localparam int NUM_OSEL = NUM_OUT + NUM_REL;

  // Input function codes
  localparam logic [7:0] FN_LIMIT_DOG  = 8'h6b;  // 107
  localparam logic [7:0] FN_FORK_SEL   = 8'h6c;  // 108
  localparam logic [7:0] FN_FEED_SW    = 8'h6d;  // 109
  localparam logic [7:0] FN_ACCEL_PAT  = 8'h6e;  // 110
  localparam logic [7:0] FN_ESTOP      = 8'h6f;  // 111
  localparam logic [7:0] FN_LIMIT_DOG2 = 8'h70;  // 112
  localparam logic [7:0] FN_EXT_MODE   = 8'h71;  // 113

  // Output function codes, positive logic; negative logic adds NEG_OFS
  localparam logic [8:0] FN_BRAKE_OPEN = 9'h014;  // 20
  localparam logic [8:0] FN_SYS_FAIL   = 9'h0e7;  // 231
  localparam logic [8:0] FN_POS_WINDOW = 9'h0e9;  // 233
  localparam logic [8:0] NEG_OFS       = 9'h064;  // 100

  // Register byte offsets
  localparam logic [11:0] ADR_IN_SEL   = 12'h000;  // 12 words, one per input terminal
  localparam logic [11:0] ADR_OUT_SEL  = 12'h040;  // 17 words, terminals then relays
  localparam logic [11:0] ADR_CTRL     = 12'h0a0;
  localparam logic [11:0] ADR_WIDTH    = 12'h0a4;
  localparam logic [11:0] ADR_TARGET   = 12'h0a8;
  localparam logic [11:0] ADR_STATUS   = 12'h0ac;
  localparam logic [11:0] ADR_IRQ_STAT = 12'h0b0;
  localparam logic [11:0] ADR_IRQ_CLR  = 12'h0b4;
  localparam logic [11:0] ADR_IRQ_EN   = 12'h0b8;

  // Control register bits
  localparam int CTRL_LIM_FAULT_EN = 0;  // Limit dog failure detection in speed feed
  localparam int CTRL_FAIL_CLR     = 1;  // Write 1 to reset the latched system failure

  // Interrupt event bits
  localparam int EV_FAIL   = 0;  // System failure detected
  localparam int EV_BRAKE  = 1;  // Brake-open request rose
  localparam int EV_WINDOW = 2;  // Position entered window
  localparam int NUM_EV    = 3;

  // Reset values
  localparam logic [7:0]  IN_SEL_RST  = 8'h00;
  localparam logic [8:0]  OUT_SEL_RST = 9'h000;
  localparam logic [31:0] WORD_RST    = 32'h0000_0000;

  typedef enum logic [1:0] {
    CDIO_STANDARD,
    CDIO_FORK,
    CDIO_POS_FEED,
    CDIO_SPEED_FEED
  } cdio_mode_t;
endpackage : cdio_pkg

// ===== cdio_map_checker.sv
/* Assertions on the ports of cdio_map: bus answer timing, decode, mode outputs.
   Assumes it is bound to cdio_map and sees only that module's ports. */
`timescale 1ns/10ps
`default_nettype none
module cdio_map_checker
  import cdio_pkg::*;
(
  input wire logic                          pclk,              // Control clock
  input wire logic                          presetn,           // Reset, active low
  input wire logic                          psel,              // Bus select
  input wire logic                          penable,           // Bus access phase
  input wire logic                          pwrite,            // Bus direction
  input wire logic [11:0]                   paddr,             // Bus address
  input wire logic [31:0]                   prdata,            // Bus read data
  input wire logic                          pready,            // Bus ready
  input wire logic                          pslverr,           // Bus error
  input wire logic [cdio_pkg::NUM_IN-1:0]   in_term,           // Input terminals
  input wire logic                          accel_pattern_sel, // Accel pattern
  input wire logic [1:0]                    op_mode            // Operating mode
);
  import cdio_pkg::*;
  logic bad_adr;
  // Holes between selector banks and above the last register are refused
  assign bad_adr = paddr[1:0] != 2'b00 || (paddr >= 12'h030 && paddr < 12'h040) ||
                   (paddr > 12'h080 && paddr < 12'h0a0) || paddr > 12'h0b8;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_access;
    $rose(psel && penable);
  endsequence
  sequence s_answer;
    pready ##1 !pready;
  endsequence
  a_wait_one: assert property (s_access |=> s_answer)
    else $error("ready not one cycle after access");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_ready_access: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  a_err_decode: assert property (pready |-> pslverr == bad_adr)
    else $error("decode error flag wrong");
  a_err_zero: assert property (pslverr |-> prdata == 32'h0)
    else $error("refused access returned data");
  a_err_only_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_accel_mode: assert property (accel_pattern_sel |-> $past(op_mode) inside {2'd2, 2'd3})
    else $error("accel pattern outside full-closed");
  // Mode moves only two edges after a pin change or right after a write
  a_mode_cause: assert property (op_mode != $past(op_mode) |-> !$past(presetn, 3) ||
    $past(in_term, 2) != $past(in_term, 3) || $past(pready && pwrite))
    else $error("mode changed without cause");
endmodule : cdio_map_checker
bind cdio_map cdio_map_checker u_cdio_map_checker (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .prdata, .pready, .pslverr, .in_term, .accel_pattern_sel, .op_mode);
`default_nettype wire

// ===== cdio_partner.sv
/* Far-side model: flux build-up behind the brake and two limit dogs.
   Assumes the bench drives run request and position on pclk. */
`timescale 1ns/10ps
`default_nettype none
module cdio_partner #(
  parameter int                 FLUX_DLY = 8,                // Flux build-up cycles
  parameter logic signed [31:0] LIM_HI   = 32'sh0000_1388,   // Upper dog position
  parameter logic signed [31:0] LIM_LO   = -32'sh0000_1388   // Lower dog position
) (
  input  wire logic               pclk,         // Control clock
  input  wire logic               presetn,      // Reset, active low
  input  wire logic               run_req,      // Start or pre-excitation on
  input  wire logic signed [31:0] position,     // Crane position
  output var  logic               flux_reached, // Flux at specified value
  output var  logic               limit_hit1,   // Upper dog struck
  output var  logic               limit_hit2    // Lower dog struck
);
  int cnt;
  // Flux takes time to build, so brake release can never be immediate
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 0;
    end else begin
      cnt <= run_req ? cnt + 1 : 0;
    end
  end
  assign flux_reached = cnt >= FLUX_DLY;
  // Dogs are track switches: level while the carriage is past them
  assign limit_hit1 = position > LIM_HI;
  assign limit_hit2 = position < LIM_LO;
endmodule : cdio_partner
`default_nettype wire

// ===== cdio_map_bench.sv
/* Self-checking bench for cdio_map with the far-side model.
   Assumes the checker is bound through its own file. */
`timescale 1ns/10ps
`default_nettype none
module cdio_map_bench;
  import cdio_pkg::*;
  logic               pclk = 1'b0;
  logic               presetn = 1'b0;
  logic               psel = 1'b0;
  logic               penable = 1'b0;
  logic               pwrite = 1'b0;
  logic [11:0]        paddr = 12'h000;
  logic [31:0]        pwdata = 32'h0;
  logic [11:0]        in_term = 12'h000;
  logic               pre_excitation_input = 1'b0;
  logic               start_input = 1'b0;
  logic signed [31:0] current_position = 32'sh0;
  logic [31:0]        prdata, rd, seed = 32'ha0c1;
  logic               pready, pslverr, flux_reached, limit_hit1, limit_hit2, accel_pattern_sel, irq, err;
  logic [6:0]         out_term;
  logic [9:0]         seq_relay;
  logic [1:0]         op_mode;
  int                 error_cnt = 0;
  int                 samples_checked = 0;
  logic [8:0]         ocode [7] = '{9'h014, 9'h078, 9'h0e9, 9'h14d, 9'h0e7, 9'h14b, 9'h005};
  always #12.5 pclk = ~pclk;
  cdio_map u_cdio_map (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .in_term, .pre_excitation_input, .start_input, .flux_reached, .limit_hit1, .limit_hit2,
    .current_position, .out_term, .seq_relay, .accel_pattern_sel, .op_mode, .irq);
  cdio_partner u_cdio_partner (.pclk, .presetn, .run_req(pre_excitation_input | start_input),
    .position(current_position), .flux_reached, .limit_hit1, .limit_hit2);
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction : xs
  function automatic logic [1:0] emode(input logic [11:0] t);
    return !t[6] ? 2'd0 : t[1] ? 2'd1 : t[2] ? 2'd3 : 2'd2;
  endfunction : emode
  // A known code plus 100 is its inverted form; every other code stays low
  function automatic logic efn(input logic [8:0] c, input logic b, f, w);
    logic [8:0] o;
    for (int k = 0; k < 2; k++) begin
      o = k[0] ? NEG_OFS : 9'h000;
      if (c == FN_BRAKE_OPEN + o) return b ^ k[0];
      if (c == FN_SYS_FAIL + o) return f ^ k[0];
      if (c == FN_POS_WINDOW + o) return w ^ k[0];
    end
    return 1'b0;
  endfunction : efn
  task automatic summarize();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : summarize
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc
  // One bus transfer; pre-edge values are what the edge samples
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
      if (n > 50) begin
        error_cnt++;
        summarize();
      end
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic outs(input logic b, f, w);
    logic [6:0] e;
    // Brake needs flux build-up plus two register stages, more than this 8-cycle settle, so callers wait 3 cycles first
    cyc(8);
    for (int i = 0; i < 7; i++) e[i] = efn(ocode[i], b, f, w);
    chk("out_term", {25'h0, out_term}, {25'h0, e});
    chk("seq_relay", {22'h0, seq_relay}, {22'h0, !w, 8'h00, f});
  endtask : outs
  initial begin
    cyc(12);
    presetn <= 1'b1;
    cyc(1);
    apb(1'b0, ADR_IN_SEL, 32'h0);
    chk("in_sel_rst", rd, 32'h0);
    apb(1'b0, 12'h030, 32'h0);
    chk("hole_err", {31'h0, err}, 32'h1);
    in_term <= 12'hfff;
    cyc(4);
    chk("mode_unassigned", {30'h0, op_mode}, 32'h0);
    for (int k = 0; k < 7; k++) apb(1'b1, ADR_IN_SEL + 12'(4 * k), 32'(k) + {24'h0, FN_LIMIT_DOG});
    for (int k = 0; k < 7; k++) apb(1'b1, ADR_OUT_SEL + 12'(4 * k), {23'h0, ocode[k]});
    apb(1'b1, ADR_OUT_SEL + 12'h01c, {23'h0, FN_SYS_FAIL});
    apb(1'b1, ADR_OUT_SEL + 12'h040, 32'h0000_014d);
    apb(1'b1, ADR_WIDTH, 32'h0000_000a);
    apb(1'b1, ADR_TARGET, 32'h0000_03e8);
    apb(1'b1, ADR_IRQ_EN, 32'h1);
    // Random levels; the five spare terminals must never matter
    repeat (40) begin
      seed = xs(seed);
      in_term <= seed[11:0];
      cyc(5);
      chk("op_mode", {30'h0, op_mode}, {30'h0, emode(seed[11:0])});
      chk("accel", {31'h0, accel_pattern_sel}, {31'h0, seed[3] && emode(seed[11:0]) >= 2'd2});
    end
    in_term <= 12'h040;
    apb(1'b1, ADR_CTRL, 32'h2);
    apb(1'b1, ADR_IRQ_CLR, 32'h7);
    current_position <= 32'sh0000_03f2;
    outs(1'b0, 1'b0, 1'b1);
    current_position <= 32'sh0000_03f3;
    outs(1'b0, 1'b0, 1'b0);
    current_position <= 32'sh0000_03e8;
    start_input <= 1'b1;
    cyc(3);
    chk("brake_early", {31'h0, out_term[0]}, 32'h0);
    outs(1'b1, 1'b0, 1'b1);
    chk("irq_masked", {31'h0, irq}, 32'h0);
    start_input <= 1'b0;
    pre_excitation_input <= 1'b1;
    outs(1'b1, 1'b0, 1'b1);
    pre_excitation_input <= 1'b0;
    in_term <= 12'h050;
    outs(1'b0, 1'b1, 1'b1);
    chk("irq_fail", {31'h0, irq}, 32'h1);
    apb(1'b0, ADR_IRQ_STAT, 32'h0);
    chk("irq_stat", rd & 32'h1, 32'h1);
    apb(1'b1, ADR_IRQ_CLR, 32'h1);
    chk("irq_clr", {31'h0, irq}, 32'h0);
    in_term <= 12'h040;
    apb(1'b1, ADR_CTRL, 32'h2);
    outs(1'b0, 1'b0, 1'b1);
    in_term <= 12'h045;
    current_position <= 32'sh0000_2000;
    outs(1'b0, 1'b0, 1'b0);
    apb(1'b1, ADR_CTRL, 32'h1);
    outs(1'b0, 1'b1, 1'b0);
    in_term <= 12'h043;
    cyc(4);
    apb(1'b1, ADR_CTRL, 32'h3);
    outs(1'b0, 1'b0, 1'b0);
    in_term <= 12'h060;
    current_position <= -32'sh0000_2000;
    outs(1'b0, 1'b1, 1'b0);
    summarize();
  end
endmodule : cdio_map_bench
`default_nettype wire
